// [hw/idio_consts.svh]
`ifndef IDIO_CONSTS_SVH
`define IDIO_CONSTS_SVH

// ----------------------------------------
// port geometry
// ----------------------------------------
`define IDIO_NCH 16
`define IDIO_WIN_BITS 5
`define IDIO_OUT_RESET 16'h0000
`define IDIO_MASK_RESET 16'hffff

// ----------------------------------------
// filter timing
// ----------------------------------------
`define IDIO_CLK_NS 25
`define IDIO_FILT_TICK_NS 1000
`define IDIO_FILT_TICK_CYC ((`IDIO_FILT_TICK_NS + `IDIO_CLK_NS - 1) / `IDIO_CLK_NS)
`define IDIO_FILT_SEL_RESET 4'h0

`endif

// [hw/idio_pkg.sv]
package idio_pkg;
	typedef logic [15:0] idio_word_t;

	typedef struct packed {
		logic [31:5] base;
		logic [3:0] filtSel;
	} idio_cfg_t;

	typedef struct packed {
		logic [15:0] level;
		logic [15:0] intStatus;
		logic intReq;
	} idio_stat_t;
endpackage

// [hw/idio_port.sv]
`timescale 1ns/10ps
`include "idio_consts.svh"

// Function
// - sixteen inputs, each readable and each usable as an interrupt source
// - all sixteen interrupt sources merged onto one shared request output
// - per input, software picks rising or falling data edge for interrupts
// - conducting input (low pin) reads as data one
// - sixteen sink outputs; data one turns transistor on, pin low
// - data zero is high pin, data one is low pin, both directions
// - thirty-two byte window decoded at any aligned base
// - digital filter rejects noise and chatter before data and interrupts
// - up to sixteen ports distinguished by software-set base address
// - reset forces every output off
module idio_port
	import idio_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [15:0] inPin,
	output logic [15:0] outPinOe_b,
	output logic [15:0] outPin,
	input wire idio_cfg_t cfg,
	input wire logic [31:0] ioAddr,
	output logic addrHit,
	input wire logic outWrEn,
	input wire idio_word_t outData,
	input wire idio_word_t edgeSel,
	input wire idio_word_t intMask,
	input wire logic ackEn,
	input wire idio_word_t ackBits,
	output idio_word_t outReadback,
	output idio_stat_t stat,
	output logic intA_b
);
	// ----------------------------------------
	// address window
	// ----------------------------------------
	// low five address bits pick a byte inside the window and are ignored
	logic [26:0] winTag;
	assign winTag = ioAddr[31:`IDIO_WIN_BITS];
	assign addrHit = (winTag == cfg.base);

	// ----------------------------------------
	// filter tick divider
	// ----------------------------------------
	logic [5:0] tickCnt_r;
	logic tick;
	assign tick = (tickCnt_r == 6'(`IDIO_FILT_TICK_CYC - 1));

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			tickCnt_r <= 6'h00;
		end else if (tick) begin
			tickCnt_r <= 6'h00;
		end else begin
			tickCnt_r <= tickCnt_r + 6'h01;
		end
	end

	// filter time in ticks is 2^sel; a table keeps the encoding plain
	logic [15:0] filtLen;
	always_comb begin
		case (cfg.filtSel)
			4'h0: filtLen = 16'h0001;
			4'h1: filtLen = 16'h0002;
			4'h2: filtLen = 16'h0004;
			4'h3: filtLen = 16'h0008;
			4'h4: filtLen = 16'h0010;
			4'h5: filtLen = 16'h0020;
			4'h6: filtLen = 16'h0040;
			4'h7: filtLen = 16'h0080;
			4'h8: filtLen = 16'h0100;
			4'h9: filtLen = 16'h0200;
			4'ha: filtLen = 16'h0400;
			4'hb: filtLen = 16'h0800;
			4'hc: filtLen = 16'h1000;
			4'hd: filtLen = 16'h2000;
			4'he: filtLen = 16'h4000;
			4'hf: filtLen = 16'h8000;
			default: filtLen = 16'h0001;
		endcase
	end

	// ----------------------------------------
	// input conditioning
	// ----------------------------------------
	idio_word_t rawData;
	idio_word_t fltData_r;
	idio_word_t fltPrev_r;
	assign rawData = ~inPin;

	// ----------------------------------------
	// per-channel filter
	// ----------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < `IDIO_NCH; ch++) begin : gChan
			logic [15:0] stab_r;
			logic fltBit_r;
			logic differ;
			logic settled;
			assign differ = (rawData[ch] != fltBit_r);
			// one tick beyond the length, as the first tick after a change is partial
			assign settled = (stab_r >= filtLen);

			always_ff @(posedge mclk) begin
				if (!rst_b) begin
					stab_r <= 16'h0000;
				end else if (!differ) begin
					stab_r <= 16'h0000;
				end else if (tick) begin
					if (settled) begin
						stab_r <= 16'h0000;
					end else begin
						stab_r <= stab_r + 16'h0001;
					end
				end
			end

			always_ff @(posedge mclk) begin
				if (!rst_b) begin
					fltBit_r <= 1'h0;
				end else if (differ && tick && settled) begin
					fltBit_r <= rawData[ch];
				end
			end
			assign fltData_r[ch] = fltBit_r;
		end
	endgenerate

	// ----------------------------------------
	// edge detection
	// ----------------------------------------
	// resets to data zero, the idle level, so no false edge follows reset
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			fltPrev_r <= 16'h0000;
		end else begin
			fltPrev_r <= fltData_r;
		end
	end

	idio_word_t rise;
	idio_word_t fall;
	idio_word_t evt;
	assign rise = fltData_r & ~fltPrev_r;
	assign fall = ~fltData_r & fltPrev_r;
	always_comb begin
		evt = 16'h0000;
		for (int i = 0; i < `IDIO_NCH; i++) begin
			if (edgeSel[i]) begin
				evt[i] = rise[i];
			end else begin
				evt[i] = fall[i];
			end
		end
	end

	// ----------------------------------------
	// interrupt status
	// ----------------------------------------
	idio_word_t status_r;
	idio_word_t ackClr;
	assign ackClr = ackEn ? ackBits : 16'h0000;

	// new edge beats a same-cycle acknowledge, so no event is lost
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			status_r <= 16'h0000;
		end else begin
			for (int i = 0; i < `IDIO_NCH; i++) begin
				if (evt[i]) begin
					status_r[i] <= 1'h1;
				end else if (ackClr[i]) begin
					status_r[i] <= 1'h0;
				end
			end
		end
	end

	// ----------------------------------------
	// shared request
	// ----------------------------------------
	// masked bits still latch, so unmasking later raises the request on the next clock
	idio_word_t pend;
	assign pend = status_r & ~intMask;
	logic intReq_r;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			intReq_r <= 1'h0;
		end else begin
			intReq_r <= |pend;
		end
	end
	assign intA_b = ~intReq_r;

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	idio_word_t out_r;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			out_r <= `IDIO_OUT_RESET;
		end else if (outWrEn) begin
			out_r <= outData;
		end
	end
	// open collector: enable low pulls the pin low; the pin never drives high
	assign outPinOe_b = ~out_r;
	assign outPin = 16'h0000;
	assign outReadback = out_r;

	// ----------------------------------------
	// status word
	// ----------------------------------------
	assign stat.level = fltData_r;
	assign stat.intStatus = status_r;
	assign stat.intReq = intReq_r;
endmodule

// [testbench/idio_field.sv]
`timescale 1ns/10ps
module idio_field (
	input wire logic [15:0] swOn,
	output logic [15:0] pinLvl
);
	assign pinLvl = ~swOn;
endmodule

// [testbench/idio_port_sva.sv]
`timescale 1ns/10ps
module idio_sva
	import idio_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire idio_word_t outPinOe_b,
	input wire logic outWrEn,
	input wire idio_word_t outData,
	input wire idio_word_t outReadback,
	input wire idio_word_t edgeSel,
	input wire idio_word_t intMask,
	input wire logic ackEn,
	input wire idio_word_t ackBits,
	input wire idio_stat_t stat,
	input wire logic intA_b
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	wire [15:0] live = stat.intStatus & ~intMask;
	a_reset_off: assert property (disable iff (0) !rst_b |=> &outPinOe_b)
		else $error("output on in reset");
	a_reset_quiet: assert property (disable iff (0) !rst_b |=> intA_b && !stat.intStatus)
		else $error("request in reset");
	a_write_sink: assert property (outWrEn |=> outPinOe_b == ~$past(outData))
		else $error("sink not per write");
	a_readback_pair: assert property (outWrEn |=> outReadback == $past(outData))
		else $error("readback wrong");
	a_out_hold: assert property (rst_b && !outWrEn |=> $stable(outPinOe_b))
		else $error("sink changed unasked");
	sequence s_edge_seen0;
		$changed(stat.level[0]) && stat.level[0] == edgeSel[0];
	endsequence
	sequence s_ack_quiet;
		ackEn && $stable(stat.level) ##1 $stable(stat.level);
	endsequence
	a_edge_latch: assert property (s_edge_seen0 |=> stat.intStatus[0])
		else $error("edge lost");
	a_ack_clear: assert property (s_ack_quiet |-> !(stat.intStatus & $past(ackBits)))
		else $error("ack ignored");
	a_req_on: assert property ((|live) [*3] |-> !intA_b)
		else $error("request missing");
	a_req_off: assert property ((live == 0) [*3] |-> intA_b)
		else $error("request stuck");
endmodule
bind idio_port idio_sva chk(.mclk, .rst_b, .outPinOe_b, .outWrEn, .outData, .outReadback,
	.edgeSel, .intMask, .ackEn, .ackBits, .stat, .intA_b);

// [testbench/tb.sv]
`timescale 1ns/10ps
module tb;
	import idio_pkg::*;
	logic mclk = 0, rst_b = 0, wr = 0, ack = 0, hit, irq_b;
	logic [31:0] ad = 0;
	idio_word_t sw = 0, pin, oe, opin, rb, od = 0, es = 16'hffff, mk = 16'hfffe, ab = 0;
	idio_cfg_t cfg = '{27'h123, 4'h0};
	idio_stat_t st;
	int errors = 0, checked = 0;
	logic [64:0] rows [2] = '{{16'h0001, 16'hfffe, 32'h247f, 1'h1},
		{16'hffff, 16'h0000, 32'h2480, 1'h0}};
	initial forever #12.5 mclk = ~mclk;
	idio_field fld(.swOn(sw), .pinLvl(pin));
	idio_port dut(.mclk, .rst_b, .inPin(pin), .outPinOe_b(oe), .outPin(opin), .cfg,
		.ioAddr(ad), .addrHit(hit), .outWrEn(wr), .outData(od), .edgeSel(es), .intMask(mk),
		.ackEn(ack), .ackBits(ab), .outReadback(rb), .stat(st), .intA_b(irq_b));
	task chk(input logic [15:0] s, e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("Error %0t %h %h", $time, s, e);
		end
	endtask
	task test_done(input int f);
		errors += f;
		if (errors == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task wt(input logic v);
		int n;
		for (n = 0; n < 300 && irq_b !== v; n++) @(negedge mclk);
		if (n == 300) test_done(1);
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		rst_b <= 1;
		@(negedge mclk) chk(oe, 16'hffff);
		foreach (rows[i]) begin
			@(posedge mclk) {wr, od, ad} <= {1'h1, rows[i][64:49], rows[i][32:1]};
			@(posedge mclk) wr <= 0;
			@(negedge mclk) chk(oe, rows[i][48:33]);
			chk(hit, rows[i][0]);
			chk(rb, rows[i][64:49]);
			chk(opin, 16'h0000);
		end
		@(posedge mclk) rst_b <= 0;
		@(posedge mclk) rst_b <= 1;
		@(negedge mclk) chk(oe, 16'hffff);
		@(posedge mclk) sw <= 16'h0003;
		wt(0);
		chk(st.intStatus, 16'h0003);
		chk(st.intReq, 16'h0001);
		@(posedge mclk) {ack, ab} <= {1'h1, 16'h0001};
		@(posedge mclk) ack <= 0;
		wt(1);
		chk(st.intStatus, 16'h0002);
		// pulses far shorter than one filter tick
		repeat (6) begin
			@(posedge mclk) sw[0] <= !sw[0];
			repeat (9) @(posedge mclk);
		end
		repeat (100) @(negedge mclk);
		chk(st.intStatus, 16'h0002);
		chk(st.level, 16'h0003);
		@(posedge mclk) {es, sw} <= 0;
		wt(0);
		chk(st.level, 16'h0000);
		@(posedge mclk) mk <= 16'hffff;
		wt(1);
		// longer filter: a 60-cycle pulse is dropped, a held change gets through
		@(posedge mclk) cfg.filtSel <= 4'h1;
		@(posedge mclk) sw[2] <= 1'h1;
		repeat (60) @(posedge mclk);
		sw[2] <= 1'h0;
		repeat (200) @(negedge mclk);
		chk(st.level, 16'h0000);
		@(posedge mclk) sw[2] <= 1'h1;
		repeat (70) @(negedge mclk);
		chk(st.level, 16'h0000);
		repeat (60) @(negedge mclk);
		chk(st.level, 16'h0004);
		test_done(0);
	end
endmodule
